/* File: logic/clock_route_pkg.sv */
// How it works
// - Route bit A set: pin one from divider one.
// - Route bit A clear: pins one, two from divider two.
// - Route bit B set: pin three from divider three.
// - Route bit B clear: pins three, six from divider six.
// - Pin zero mode: x0 tristate, 01 low, 11 high.
// - Pair B mode governs pins three and six.
`default_nettype none

package clock_route_pkg;

  // Register addresses on the configuration port.
  localparam logic [7:0] ADDR_RSVD_A = 8'h74;
  localparam logic [7:0] ADDR_ZERO_ROUTE = 8'h75;
  localparam logic [7:0] ADDR_PAIR_A = 8'h76;
  localparam logic [7:0] ADDR_GROUP_TWO = 8'h77;
  localparam logic [7:0] ADDR_PAIR_B = 8'h78;
  localparam logic [7:0] ADDR_RSVD_B = 8'h79;
  localparam logic [7:0] ADDR_RSVD_C = 8'h7a;
  localparam logic [7:0] ADDR_SIX_SLEW = 8'h7b;

  // Reset values.
  localparam logic [7:0] RST_RSVD_A = 8'h01;
  localparam logic [7:0] RST_ZERO_ROUTE = 8'h03;
  localparam logic [7:0] RST_PAIR_A = 8'h00;
  localparam logic [7:0] RST_GROUP_TWO = 8'h00;
  localparam logic [7:0] RST_PAIR_B = 8'h00;
  localparam logic [7:0] RST_RSVD_B = 8'h00;
  localparam logic [7:0] RST_RSVD_C = 8'h00;
  localparam logic [7:0] RST_SIX_SLEW = 8'h00;

  // Writable bits of each register; reserved bits read as zero.
  localparam logic [7:0] MASK_ZERO_ROUTE = 8'hfb;
  localparam logic [7:0] MASK_GROUP = 8'hfc;
  localparam logic [7:0] MASK_SIX_SLEW = 8'h30;

  // Field positions.
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int SLEW_HI = 5;
  localparam int SLEW_LO = 4;
  localparam int INV_FIRST = 3;
  localparam int INV_SECOND = 2;
  localparam int ROUTE_A_BIT = 1;
  localparam int ROUTE_B_BIT = 0;

  // Enable-mode codes: bit 0 clear tristates, otherwise bit 1 is the parked level.
  localparam logic [1:0] MODE_TRISTATE = 2'b00;
  localparam logic [1:0] MODE_PARK_LOW = 2'b01;
  localparam logic [1:0] MODE_PARK_HIGH = 2'b11;
  localparam int MODE_PARK_BIT = 0;
  localparam int MODE_LEVEL_BIT = 1;

  // Pin slots in the output stage.
  localparam int NUM_PINS = 5;
  localparam int PIN_ZERO = 0;
  localparam int PIN_ONE = 1;
  localparam int PIN_TWO = 2;
  localparam int PIN_THREE = 3;
  localparam int PIN_SIX = 4;

  typedef logic [NUM_PINS-1:0] pin_vec_t;
  typedef logic [NUM_PINS-1:0][1:0] mode_vec_t;

endpackage

`default_nettype wire

/* File: logic/pin_stage_if.sv */
`default_nettype none

// Carries the selected clocks and controls into the pin stage and its pin levels back.
interface pin_stage_if;
  clock_route_pkg::pin_vec_t src;
  clock_route_pkg::pin_vec_t invert;
  clock_route_pkg::mode_vec_t mode;
  logic drive_en;
  clock_route_pkg::pin_vec_t level;
  clock_route_pkg::pin_vec_t oe_n;

  modport ctrl (output src, output invert, output mode, output drive_en, input level, input oe_n);
  modport stage (input src, input invert, input mode, input drive_en, output level, output oe_n);
endinterface

`default_nettype wire

/* File: logic/clock_pin_stage.sv */
`default_nettype none

module clock_pin_stage (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Controls in, pin levels out.
  pin_stage_if.stage bus
);
  import clock_route_pkg::*;

  typedef struct packed {
    pin_vec_t level;
    pin_vec_t oe_n;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // Each pin either runs its clock or sits in the state its enable mode picks.
  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (bus.drive_en) begin
        state_next.level[i] = bus.src[i] ^ bus.invert[i];
        state_next.oe_n[i] = 1'b0;
      end else if (!bus.mode[i][MODE_PARK_BIT]) begin
        state_next.level[i] = 1'b0;
        state_next.oe_n[i] = 1'b1;
      end else begin
        state_next.level[i] = bus.mode[i][MODE_LEVEL_BIT];
        state_next.oe_n[i] = 1'b0;
      end
    end
  end

  // Pins start tristated.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '{level: '0, oe_n: '1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus.level = state_reg.level;
  assign bus.oe_n = state_reg.oe_n;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_zero_park_low: assert property (!bus.drive_en && bus.mode[PIN_ZERO] == MODE_PARK_LOW
    |=> !bus.level[PIN_ZERO] && !bus.oe_n[PIN_ZERO]) else $error("Pin zero not parked low.");
  a_zero_park_high: assert property (!bus.drive_en && bus.mode[PIN_ZERO] == MODE_PARK_HIGH
    |=> bus.level[PIN_ZERO] && !bus.oe_n[PIN_ZERO]) else $error("Pin zero not parked high.");
  a_zero_tristate: assert property (!bus.drive_en && !bus.mode[PIN_ZERO][MODE_PARK_BIT]
    |=> bus.oe_n[PIN_ZERO]) else $error("Pin zero not tristated.");
  c_park_high: cover property (!bus.drive_en && bus.mode[PIN_ZERO] == MODE_PARK_HIGH);
endmodule

`default_nettype wire

/* File: logic/clock_output_routing_control.sv */
`default_nettype none

module clock_output_routing_control #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Configuration register port.
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [ADDR_W-1:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  // Divider outputs and the global output enable.
  input wire logic divider_zero,
  input wire logic divider_one,
  input wire logic divider_two,
  input wire logic divider_three,
  input wire logic divider_six,
  input wire logic outputs_enable,
  // Clock pins, each with an active-low output enable.
  output logic clock_pin_zero,
  output logic clock_pin_zero_oe_n,
  output logic clock_pin_one,
  output logic clock_pin_one_oe_n,
  output logic clock_pin_two,
  output logic clock_pin_two_oe_n,
  output logic clock_pin_three,
  output logic clock_pin_three_oe_n,
  output logic clock_pin_six,
  output logic clock_pin_six_oe_n,
  // Edge-rate codes for the pad drivers.
  output logic [1:0] out_zero_edge_rate,
  output logic [1:0] out_pair_a_edge_rate,
  output logic [1:0] out_group_two_edge_rate,
  output logic [1:0] out_pair_b_edge_rate,
  output logic [1:0] out_six_edge_rate
);
  import clock_route_pkg::*;

  // The register map spans eight-bit addresses.
  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must be at least 8.");
  end

  typedef struct packed {
    logic [7:0] zero_route;
    logic [7:0] pair_a;
    logic [7:0] group_two;
    logic [7:0] pair_b;
    logic [7:0] six_slew;
    logic [7:0] rdata;
    logic rvalid;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic addr_in_map;
  logic [7:0] addr_low;
  logic route_a;
  logic route_b;

  pin_stage_if stage_bus ();

  // Picks the pin's own divider when its route bit is set, else the shared one.
  function automatic logic route_pick(input logic sel, input logic own, input logic shared);
    route_pick = sel ? own : shared;
  endfunction

  // Reads back a register by address; unmapped addresses return zero.
  function automatic logic [7:0] read_mux(input state_s s, input logic [7:0] a);
    case (a)
      ADDR_RSVD_A: read_mux = RST_RSVD_A;
      ADDR_ZERO_ROUTE: read_mux = s.zero_route;
      ADDR_PAIR_A: read_mux = s.pair_a;
      ADDR_GROUP_TWO: read_mux = s.group_two;
      ADDR_PAIR_B: read_mux = s.pair_b;
      ADDR_RSVD_B: read_mux = RST_RSVD_B;
      ADDR_RSVD_C: read_mux = RST_RSVD_C;
      ADDR_SIX_SLEW: read_mux = s.six_slew;
      default: read_mux = 8'h00;
    endcase
  endfunction

  // Upper address bits, if any, must be zero for a hit.
  always_comb begin
    addr_low = cfg_addr[7:0];
    addr_in_map = 1'b1;
    if (ADDR_W > 8) begin
      addr_in_map = (cfg_addr >> 8) == '0;
    end
  end

  // Register writes keep only writable bits; reads answer one cycle later.
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = cfg_rd_en;
    if (cfg_rd_en) begin
      state_next.rdata = addr_in_map ? read_mux(state_reg, addr_low) : 8'h00;
    end
    if (cfg_wr_en && addr_in_map) begin
      case (addr_low)
        ADDR_ZERO_ROUTE: state_next.zero_route = cfg_wdata & MASK_ZERO_ROUTE;
        ADDR_PAIR_A: state_next.pair_a = cfg_wdata & MASK_GROUP;
        ADDR_GROUP_TWO: state_next.group_two = cfg_wdata & MASK_GROUP;
        ADDR_PAIR_B: state_next.pair_b = cfg_wdata & MASK_GROUP;
        ADDR_SIX_SLEW: state_next.six_slew = cfg_wdata & MASK_SIX_SLEW;
        default: state_next.zero_route = state_reg.zero_route;
      endcase
    end
  end

  // Registers load their documented defaults.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '{zero_route: RST_ZERO_ROUTE, pair_a: RST_PAIR_A, group_two: RST_GROUP_TWO,
                     pair_b: RST_PAIR_B, six_slew: RST_SIX_SLEW, rdata: 8'h00, rvalid: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign route_a = state_reg.zero_route[ROUTE_A_BIT];
  assign route_b = state_reg.zero_route[ROUTE_B_BIT];

  // Route matrix: pins one and three take their divider as the route bits choose; pins zero, two and six are fixed.
  always_comb begin
    stage_bus.src[PIN_ZERO] = divider_zero;
    stage_bus.src[PIN_ONE] = route_pick(route_a, divider_one, divider_two);
    stage_bus.src[PIN_TWO] = divider_two;
    stage_bus.src[PIN_THREE] = route_pick(route_b, divider_three, divider_six);
    stage_bus.src[PIN_SIX] = divider_six;
  end

  // Inversion bits; for a pair the upper bit serves the first pin.
  always_comb begin
    stage_bus.invert[PIN_ZERO] = state_reg.zero_route[INV_FIRST];
    stage_bus.invert[PIN_ONE] = state_reg.pair_a[INV_FIRST];
    stage_bus.invert[PIN_TWO] = state_reg.pair_a[INV_SECOND];
    stage_bus.invert[PIN_THREE] = state_reg.pair_b[INV_FIRST];
    stage_bus.invert[PIN_SIX] = state_reg.pair_b[INV_SECOND];
  end

  // Enable modes: pin zero alone, pair A shared, pair B shared by pins three and six.
  always_comb begin
    stage_bus.mode[PIN_ZERO] = state_reg.zero_route[MODE_HI:MODE_LO];
    stage_bus.mode[PIN_ONE] = state_reg.pair_a[MODE_HI:MODE_LO];
    stage_bus.mode[PIN_TWO] = state_reg.pair_a[MODE_HI:MODE_LO];
    stage_bus.mode[PIN_THREE] = state_reg.pair_b[MODE_HI:MODE_LO];
    stage_bus.mode[PIN_SIX] = state_reg.pair_b[MODE_HI:MODE_LO];
    stage_bus.drive_en = outputs_enable;
  end

  clock_pin_stage u_stage (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .bus(stage_bus.stage)
  );

  // Outputs come straight from the register and pin-stage flops.
  assign cfg_rdata = state_reg.rdata;
  assign cfg_rvalid = state_reg.rvalid;
  assign clock_pin_zero = stage_bus.level[PIN_ZERO];
  assign clock_pin_zero_oe_n = stage_bus.oe_n[PIN_ZERO];
  assign clock_pin_one = stage_bus.level[PIN_ONE];
  assign clock_pin_one_oe_n = stage_bus.oe_n[PIN_ONE];
  assign clock_pin_two = stage_bus.level[PIN_TWO];
  assign clock_pin_two_oe_n = stage_bus.oe_n[PIN_TWO];
  assign clock_pin_three = stage_bus.level[PIN_THREE];
  assign clock_pin_three_oe_n = stage_bus.oe_n[PIN_THREE];
  assign clock_pin_six = stage_bus.level[PIN_SIX];
  assign clock_pin_six_oe_n = stage_bus.oe_n[PIN_SIX];
  assign out_zero_edge_rate = state_reg.zero_route[SLEW_HI:SLEW_LO];
  assign out_pair_a_edge_rate = state_reg.pair_a[SLEW_HI:SLEW_LO];
  assign out_group_two_edge_rate = state_reg.group_two[SLEW_HI:SLEW_LO];
  assign out_pair_b_edge_rate = state_reg.pair_b[SLEW_HI:SLEW_LO];
  assign out_six_edge_rate = state_reg.six_slew[SLEW_HI:SLEW_LO];

  // Expected pin levels, seen by the checks below only.
  logic exp_one_split;
  logic exp_one_shared;
  logic exp_three_split;
  logic exp_three_shared;
  logic exp_two;
  logic exp_six;
  assign exp_one_split = divider_one ^ state_reg.pair_a[INV_FIRST];
  assign exp_one_shared = divider_two ^ state_reg.pair_a[INV_FIRST];
  assign exp_three_split = divider_three ^ state_reg.pair_b[INV_FIRST];
  assign exp_three_shared = divider_six ^ state_reg.pair_b[INV_FIRST];
  assign exp_two = divider_two ^ state_reg.pair_a[INV_SECOND];
  assign exp_six = divider_six ^ state_reg.pair_b[INV_SECOND];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_pin_one_split: assert property (route_a && outputs_enable
    |=> clock_pin_one == $past(exp_one_split) && !clock_pin_one_oe_n) else $error("Pin one not from divider one.");
  a_pin_one_shared: assert property (!route_a && outputs_enable
    |=> clock_pin_one == $past(exp_one_shared)) else $error("Pin one not from divider two.");
  a_pin_three_split: assert property (route_b && outputs_enable
    |=> clock_pin_three == $past(exp_three_split)) else $error("Pin three not from divider three.");
  a_pin_three_shared: assert property (!route_b && outputs_enable
    |=> clock_pin_three == $past(exp_three_shared)) else $error("Pin three not from divider six.");
  a_pair_b_mode: assert property (!outputs_enable
    |=> clock_pin_three_oe_n == clock_pin_six_oe_n) else $error("Pins three and six disagree on enable.");
  a_pin_two_invert: assert property (outputs_enable
    |=> clock_pin_two == $past(exp_two)) else $error("Pin two inversion wrong.");
  a_pin_six_fixed: assert property (outputs_enable
    |=> clock_pin_six == $past(exp_six) && !clock_pin_six_oe_n) else $error("Pin six not from divider six.");
  a_zero_mode_only: assert property (!outputs_enable
    ##1 !outputs_enable && $stable(state_reg.zero_route) |=> $stable(clock_pin_zero_oe_n))
    else $error("Pin zero enable moved without a mode change.");
  a_read_answer: assert property (cfg_rd_en |=> cfg_rvalid ##1 !cfg_rvalid || $past(cfg_rd_en))
    else $error("Read answer not one cycle long.");

  c_split_routes: cover property (route_a && route_b && outputs_enable);
  c_shared_routes: cover property (!route_a && !route_b && outputs_enable);
  c_pair_b_park: cover property (!outputs_enable && state_reg.pair_b[MODE_HI:MODE_LO] == MODE_PARK_HIGH);
  c_write_then_read: cover property (cfg_wr_en ##1 cfg_rd_en ##1 cfg_rvalid);
endmodule

`default_nettype wire

/* File: sim/tb.sv */
`default_nettype none
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin failures++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import clock_route_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic cfg_wr_en = 1'b0;
  logic cfg_rd_en = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  logic [4:0] div = 5'h00;
  logic outputs_enable = 1'b0;
  logic [4:0] lvl;
  logic [4:0] oe_n;
  logic [9:0] rates;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;

  // Bit order of the pin vectors is six, three, two, one, zero.
  clock_output_routing_control i_clock_output_routing_control (
    .clk_sys(clk_sys), .arst_n(arst_n), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .divider_zero(div[0]), .divider_one(div[1]), .divider_two(div[2]), .divider_three(div[3]),
    .divider_six(div[4]), .outputs_enable(outputs_enable),
    .clock_pin_zero(lvl[0]), .clock_pin_zero_oe_n(oe_n[0]), .clock_pin_one(lvl[1]),
    .clock_pin_one_oe_n(oe_n[1]), .clock_pin_two(lvl[2]), .clock_pin_two_oe_n(oe_n[2]),
    .clock_pin_three(lvl[3]), .clock_pin_three_oe_n(oe_n[3]), .clock_pin_six(lvl[4]),
    .clock_pin_six_oe_n(oe_n[4]), .out_zero_edge_rate(rates[1:0]), .out_pair_a_edge_rate(rates[3:2]),
    .out_group_two_edge_rate(rates[5:4]), .out_pair_b_edge_rate(rates[7:6]), .out_six_edge_rate(rates[9:8])
  );

  // Free-running core clock at 40 MHz.
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Cuts a hung run short well after the tests should have ended.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      summarize();
    end
  end

  // Inputs always change the same small delay after the rising edge.
  task automatic step();
    @(posedge clk_sys);
    #2;
  endtask

  // Strobes are lowered and an edge passes before the next request.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    step();
    cfg_wr_en = 1'b0;
    step();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    cfg_rd_en = 1'b1;
    cfg_addr = a;
    step();
    cfg_rd_en = 1'b0;
    `CHK("cfg_rvalid", 1'b1, cfg_rvalid)
    `CHK("cfg_rdata", exp, cfg_rdata)
    step();
  endtask

  // Pins follow their inputs one edge late, so two edges are allowed.
  task automatic pins_chk(input logic [4:0] exp_lvl, input logic [4:0] exp_oe_n);
    step();
    step();
    `CHK("pin levels", exp_lvl, lvl)
    `CHK("pin enables", exp_oe_n, oe_n)
  endtask

  // Reset values of every register and of an unmapped place.
  task automatic t_reset();
    logic [7:0] addrs [9] = '{8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h80};
    logic [7:0] vals [9] = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) begin
      rd_chk(addrs[i], vals[i]);
    end
  endtask

  // All ones written everywhere; only writable bits stick, reserved places stay put.
  task automatic t_masks();
    logic [7:0] addrs [9] = '{8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h80};
    logic [7:0] vals [9] = '{8'h01, 8'hfb, 8'hfc, 8'hfc, 8'hfc, 8'h00, 8'h00, 8'h30, 8'h00};
    for (int i = 0; i < 9; i++) begin
      wr(addrs[i], 8'hff);
    end
    for (int i = 0; i < 9; i++) begin
      rd_chk(addrs[i], vals[i]);
    end
    `CHK("edge rates", 10'h3ff, rates)
    for (int i = 0; i < 9; i++) begin
      wr(addrs[i], 8'h00);
    end
    `CHK("edge rates", 10'h000, rates)
  endtask

  // Every route setting with two opposite divider patterns.
  task automatic t_route();
    logic [4:0] pats [2] = '{5'b10101, 5'b01010};
    logic [4:0] e;
    outputs_enable = 1'b1;
    for (int r = 0; r < 4; r++) begin
      wr(8'h75, {6'h00, r[1:0]});
      for (int p = 0; p < 2; p++) begin
        div = pats[p];
        e = {div[4], r[0] ? div[3] : div[4], div[2], r[1] ? div[1] : div[2], div[0]};
        pins_chk(e, 5'b00000);
      end
    end
  endtask

  // Disabled outputs follow their mode; pair B is given a different code from pin zero.
  task automatic t_modes();
    logic [1:0] c2;
    logic z;
    logic [1:0] s;
    outputs_enable = 1'b0;
    div = 5'b11111;
    wr(8'h76, 8'hc0);
    for (int c = 0; c < 4; c++) begin
      c2 = c[1:0] ^ 2'b01;
      wr(8'h75, {c[1:0], 6'h03});
      wr(8'h78, {c2, 6'h00});
      z = c[0] & c[1];
      s = {2{c2[0] & c2[1]}};
      pins_chk({s, 2'b11, z}, {{2{~c2[0]}}, 2'b00, ~c[0]});
    end
  endtask

  // Each invert bit flips only its own pin.
  task automatic t_invert();
    outputs_enable = 1'b1;
    div = 5'b00000;
    wr(8'h75, 8'h0b);
    wr(8'h76, 8'h08);
    wr(8'h78, 8'h04);
    pins_chk(5'b10011, 5'b00000);
    wr(8'h76, 8'h04);
    wr(8'h78, 8'h08);
    pins_chk(5'b01101, 5'b00000);
    div = 5'b11111;
    pins_chk(5'b10010, 5'b00000);
  endtask

  // A second reset in mid-run tristates every pin and restores the register defaults.
  task automatic t_rereset();
    outputs_enable = 1'b1;
    div = 5'b00000;
    wr(8'h76, 8'h3c);
    arst_n = 1'b0;
    #5;
    `CHK("pin enables in reset", 5'b11111, oe_n)
    `CHK("edge rates in reset", 10'h000, rates)
    `CHK("cfg_rvalid in reset", 1'b0, cfg_rvalid)
    step();
    arst_n = 1'b1;
    pins_chk(5'b00000, 5'b00000);
    rd_chk(8'h75, 8'h03);
    rd_chk(8'h76, 8'h00);
  endtask

  // Back-to-back strobes: a read beside a write sees the old value, the next read the new one.
  task automatic t_back_to_back();
    cfg_wr_en = 1'b1;
    cfg_rd_en = 1'b1;
    cfg_addr = 8'h77;
    cfg_wdata = 8'ha4;
    step();
    cfg_wr_en = 1'b0;
    `CHK("cfg_rdata beside write", 8'h00, cfg_rdata)
    step();
    cfg_rd_en = 1'b0;
    `CHK("cfg_rvalid after write", 1'b1, cfg_rvalid)
    `CHK("cfg_rdata after write", 8'ha4, cfg_rdata)
    step();
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence: ten cycles of reset, then the scenarios in turn.
  initial begin
    repeat (10) @(posedge clk_sys);
    #2;
    `CHK("pin enables in reset", 5'b11111, oe_n)
    arst_n = 1'b1;
    step();
    t_reset();
    t_masks();
    t_route();
    t_modes();
    t_invert();
    t_rereset();
    t_back_to_back();
    summarize();
  end
endmodule

`default_nettype wire
